// ---- core/ste_consts.svh ----
// Register map, field positions, reset values and counts of the serial channel
`ifndef STE_CONSTS_SVH
`define STE_CONSTS_SVH
`define STE_A_CTRL   8'h00
`define STE_A_TXD    8'h04
`define STE_A_STAT   8'h08
`define STE_A_IRQ    8'h0C
`define STE_A_MASK   8'h10
`define STE_A_RXD    8'h14
`define STE_C_TXE    0
`define STE_C_RXE    1
`define STE_C_SM     3:2
`define STE_C_DBUF   4
`define STE_C_FIFO   5
`define STE_C_CKOUT  6
`define STE_C_EDGE   7
`define STE_C_FIS    8
`define STE_C_THR    10:9
`define STE_C_PEN    11
`define STE_C_LEN    13:12
`define STE_C_SRST   15:14
`define STE_C_IDLE   16
`define STE_C_ODD    17
`define STE_CTRL_W   18
`define STE_CTRL_RST 18'h00000
`define STE_MASK_RST 5'h00
`define STE_SM_IO    2'h0
`define STE_LEN7     2'h0
`define STE_LEN9     2'h2
`define STE_SR_ARM   2'h2
`define STE_SR_GO    2'h1
`define STE_I_TX     0
`define STE_I_OVR    1
`define STE_I_PUN    2
`define STE_I_FRM    3
`define STE_I_RX     4
`define STE_IRQ_W    5
`define STE_IO_BITS  4'h8
`define STE_IO_LAST  4'h7
`endif

// ---- core/ste_core.sv ----
// Serial channel with transmit interrupt and error timing, APB registers
// How it works
// - Async single buffer: transmit interrupt just before the stop bit starts
// - Clocked single buffer: interrupt right after the last selected clock edge
// - Async double buffer: interrupt when buffer word moves into shifter
// - Double buffer, enabled and shifter empty: written word moves straight in, interrupting
// - FIFO, select 0: interrupt when level equals threshold, on pop or write
// - FIFO, select 1: interrupt when level below threshold, on write only
// - Async: framing and overrun flagged at middle of stop bit
// - Parity judged mid parity bit, flagged mid stop bit; none for 9 bits
// - Clocked mode: overrun flagged right after last selected edge of word
// - Clocked mode: underrun flagged on next selected edge with no word ready
// - Own clock output: overrun and underrun are never raised
// - Soft reset clears enables, buffer, running, error flags; engines idle
// - Mode field 00 selects clocked I/O mode
// - Clocked mode either drives the serial clock or takes it from outside
// - Clock out, single buffer: each write starts clock and shifting
// - Clock out, double buffer: move on write-when-empty or word end, interrupt
// - Clock out, double buffer, nothing queued at word end: clock stops quietly
`include "ste_consts.svh"
module ste_core
  import ste_pkg::*;
#(
  parameter int BIT_CYCLES = 16,
  parameter int SCK_HALF   = 8,
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe,
  output logic             transmit_line_pin,
  input  wire logic        receive_line_pin,
  output logic             transmit_interrupt
);
  localparam int BW = $clog2(BIT_CYCLES + 1);
  localparam int HW = $clog2(SCK_HALF + 1);
  localparam int PW = $clog2(FIFO_DEPTH);

  if (BIT_CYCLES < 4 || SCK_HALF < 2 || FIFO_DEPTH < 2 || FIFO_DEPTH > 4 ||
      (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk
    $error("ste_core: unsupported parameter value");
  end

  function automatic logic is_map(input logic [7:0] a);
    return a == `STE_A_CTRL || a == `STE_A_TXD || a == `STE_A_STAT ||
           a == `STE_A_IRQ || a == `STE_A_MASK || a == `STE_A_RXD;
  endfunction

  function automatic logic par_of(input logic [8:0] d, input logic [1:0] len,
                                  input logic odd);
    return (len == `STE_LEN7) ? (odd ^ (^d[6:0])) : (odd ^ (^d[7:0]));
  endfunction

  logic [`STE_CTRL_W-1:0]  ctrl_r;
  logic [`STE_IRQ_W-1:0]   mask_r;
  logic [`STE_IRQ_W-1:0]   ist_r;
  logic [`STE_IRQ_W-1:0]   ev;
  logic [31:0]             prdata_r;
  logic                    sr_arm_r;
  logic                    ck_s1_r;
  logic                    ck_s2_r;
  logic                    rx_s1_r;
  logic                    rx_s2_r;
  logic                    sck_d_r;
  logic                    sck_o_r;
  logic [HW-1:0]           half_r;
  logic [8:0]              fifo_r [FIFO_DEPTH];
  logic [PW-1:0]           wp_r;
  logic [PW-1:0]           rp_r;
  logic [2:0]              lvl_r;
  logic [2:0]              lvl_nxt;
  logic [8:0]              buf_r;
  logic                    buf_full_r;
  logic [11:0]             sh_r;
  logic [3:0]              cnt_r;
  logic [BW-1:0]           bt_r;
  logic                    tx_run_r;
  logic                    smp_r;
  ste_rx_state_type        st_r;
  logic [BW-1:0]           rc_r;
  logic [3:0]              ri_r;
  logic [8:0]              rsh_r;
  logic [8:0]              rxb_r;
  logic                    rx_full_r;
  logic                    parity_underrun_error_flag_pend_r;
  logic                    ovr_r;
  logic                    pun_r;
  logic                    frm_r;
  logic                    wr_en;
  logic                    rd_en;
  logic                    ctrl_wr;
  logic                    txd_wr;
  logic                    stat_rd;
  logic                    irq_rd;
  logic                    rxd_rd;
  logic                    srst;
  logic                    io;
  logic                    txe;
  logic                    receive_enable_bit;
  logic                    dbuf;
  logic                    fifo;
  logic                    ckout;
  logic                    edge_sel;
  logic                    pe;
  logic [1:0]              len;
  logic [3:0]              dbits;
  logic [2:0]              thr;
  logic                    sck;
  logic                    act;
  logic                    inact;
  logic                    rxs;
  logic                    f_push;
  logic                    f_pop;
  logic                    ld;
  logic                    u_stop;
  logic                    io_last;
  logic                    tx_ev;
  logic                    fifo_ev;
  logic                    u_mid;
  logic                    io_rx_last;
  logic                    rx_word;
  logic                    rx_acc;
  logic                    ovr_ev;
  logic                    pun_ev;
  logic                    frm_ev;
  logic [8:0]              rx_val;
  logic [11:0]             frame;
  logic [BW-1:0]           bit_full;
  logic [BW-1:0]           bit_half;

  // APB decode, zero wait states
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~is_map(paddr);
  assign prdata  = prdata_r;
  assign ctrl_wr = wr_en & (paddr == `STE_A_CTRL);
  assign txd_wr  = wr_en & (paddr == `STE_A_TXD);
  assign stat_rd = rd_en & (paddr == `STE_A_STAT);
  assign irq_rd  = rd_en & (paddr == `STE_A_IRQ);
  assign rxd_rd  = rd_en & (paddr == `STE_A_RXD);

  // Control fields
  assign io       = ctrl_r[`STE_C_SM] == `STE_SM_IO;
  assign txe      = ctrl_r[`STE_C_TXE];
  assign receive_enable_bit      = ctrl_r[`STE_C_RXE];
  assign dbuf     = ctrl_r[`STE_C_DBUF];
  assign fifo     = ctrl_r[`STE_C_FIFO];
  assign ckout    = ctrl_r[`STE_C_CKOUT];
  assign edge_sel = ctrl_r[`STE_C_EDGE];
  assign len      = ctrl_r[`STE_C_LEN];
  assign pe       = ctrl_r[`STE_C_PEN] & (len != `STE_LEN9);
  assign thr      = {1'b0, ctrl_r[`STE_C_THR]};
  assign dbits    = (len == `STE_LEN7) ? 4'h7 : (len == `STE_LEN9) ? 4'h9 : 4'h8;
  assign bit_full = BW'(BIT_CYCLES - 1);
  assign bit_half = BW'(BIT_CYCLES / 2 - 1);

  // Soft reset only on the ordered pair of writes
  assign srst = ctrl_wr & sr_arm_r & (pwdata[`STE_C_SRST] == `STE_SR_GO);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= `STE_CTRL_RST;
      sr_arm_r <= 1'b0;
    end else if (ctrl_wr) begin
      ctrl_r   <= pwdata[`STE_CTRL_W-1:0];
      sr_arm_r <= pwdata[`STE_C_SRST] == `STE_SR_ARM;
      if (srst) begin
        ctrl_r[`STE_C_TXE] <= 1'b0;
        ctrl_r[`STE_C_RXE] <= 1'b0;
      end
    end
  end

  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end else begin
      ck_s1_r <= serial_clock_pin_i;
      ck_s2_r <= ck_s1_r;
      rx_s1_r <= receive_line_pin;
      rx_s2_r <= rx_s1_r;
    end
  end

  // Serial clock source and edge detect
  assign sck   = ckout ? sck_o_r : ck_s2_r;
  assign act   = (sck != sck_d_r) & (sck == edge_sel);
  assign inact = (sck != sck_d_r) & (sck != edge_sel);
  assign rxs   = rx_s2_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_d_r <= 1'b0;
    end else begin
      sck_d_r <= sck;
    end
  end

  // Clock generator: runs while a word shifts, then parks at idle level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_o_r <= 1'b0;
      half_r  <= '0;
    end else if (io && ckout && (tx_run_r || sck_o_r == edge_sel)) begin
      if (half_r == HW'(SCK_HALF - 1)) begin
        half_r  <= '0;
        sck_o_r <= ~sck_o_r;
      end else begin
        half_r <= half_r + HW'(1);
      end
    end else begin
      half_r  <= '0;
      sck_o_r <= ~edge_sel;
    end
  end

  assign serial_clock_pin_o  = sck_o_r;
  assign serial_clock_pin_oe = io & ckout;

  // Transmit FIFO
  assign f_push  = fifo & txd_wr & (lvl_r != 3'(FIFO_DEPTH));
  assign f_pop   = fifo & (lvl_r != 3'h0) & ~buf_full_r;
  assign lvl_nxt = lvl_r + 3'(f_push) - 3'(f_pop);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r  <= '0;
      rp_r  <= '0;
      lvl_r <= 3'h0;
    end else begin
      if (f_push) begin
        fifo_r[wp_r] <= pwdata[8:0];
        wp_r         <= wp_r + PW'(1);
      end
      if (f_pop) begin
        rp_r <= rp_r + PW'(1);
      end
      lvl_r <= lvl_nxt;
    end
  end

  // Transmit buffer
  assign ld = buf_full_r & txe & ~tx_run_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_r      <= 9'h000;
      buf_full_r <= 1'b0;
    end else if (srst) begin
      buf_full_r <= 1'b0;
    end else if (ld) begin
      buf_full_r <= 1'b0;
    end else if (f_pop) begin
      buf_r      <= fifo_r[rp_r];
      buf_full_r <= 1'b1;
    end else if (txd_wr && !fifo && !buf_full_r) begin
      buf_r      <= pwdata[8:0];
      buf_full_r <= 1'b1;
    end
  end

  // Async frame: start, data, optional parity, stop, idle ones above
  always_comb begin
    frame = 12'hFFF;
    frame[0] = 1'b0;
    if (len == `STE_LEN7) begin
      frame[7:1] = buf_r[6:0];
      if (pe) frame[8] = par_of(buf_r, len, ctrl_r[`STE_C_ODD]);
    end else if (len == `STE_LEN9) begin
      frame[9:1] = buf_r;
    end else begin
      frame[8:1] = buf_r[7:0];
      if (pe) frame[9] = par_of(buf_r, len, ctrl_r[`STE_C_ODD]);
    end
  end

  // Transmit shifter
  assign u_stop  = tx_run_r & ~io & (bt_r == '0) & (cnt_r == 4'h2);
  assign io_last = tx_run_r & io & act & (cnt_r == 4'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_r     <= 12'hFFF;
      cnt_r    <= 4'h0;
      bt_r     <= '0;
      tx_run_r <= 1'b0;
      smp_r    <= 1'b0;
    end else if (srst) begin
      tx_run_r <= 1'b0;
      cnt_r    <= 4'h0;
      smp_r    <= 1'b0;
    end else if (ld) begin
      tx_run_r <= 1'b1;
      smp_r    <= 1'b0;
      bt_r     <= bit_full;
      if (io) begin
        sh_r  <= {4'hF, buf_r[7:0]};
        cnt_r <= `STE_IO_BITS;
      end else begin
        sh_r  <= frame;
        cnt_r <= dbits + 4'h2 + 4'(pe);
      end
    end else if (tx_run_r && io) begin
      if (act) begin
        smp_r <= 1'b1;
        cnt_r <= cnt_r - 4'h1;
        if (cnt_r == 4'h1) tx_run_r <= 1'b0;
      end else if (inact && smp_r) begin
        smp_r <= 1'b0;
        sh_r  <= {1'b1, sh_r[11:1]};
      end
    end else if (tx_run_r) begin
      if (bt_r == '0) begin
        bt_r  <= bit_full;
        sh_r  <= {1'b1, sh_r[11:1]};
        cnt_r <= cnt_r - 4'h1;
        if (cnt_r == 4'h1) tx_run_r <= 1'b0;
      end else begin
        bt_r <= bt_r - BW'(1);
      end
    end
  end

  assign transmit_line_pin = tx_run_r ? sh_r[0] : (io ? ctrl_r[`STE_C_IDLE] : 1'b1);

  // Transmit interrupt source by buffering
  assign fifo_ev = ctrl_r[`STE_C_FIS] ? (f_push & (lvl_nxt < thr))
                                      : ((f_push | f_pop) & (lvl_nxt == thr));
  assign tx_ev = fifo ? fifo_ev
               : dbuf ? ld
               : (u_stop | io_last);

  // Receiver: clocked shift-in in I/O mode, async frame states otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r        <= ste_rx_idle;
      rc_r        <= '0;
      ri_r        <= 4'h0;
      rsh_r       <= 9'h000;
      parity_underrun_error_flag_pend_r <= 1'b0;
    end else if (srst) begin
      st_r <= ste_rx_idle;
      ri_r <= 4'h0;
    end else if (io) begin
      st_r <= ste_rx_idle;
      if (receive_enable_bit && act) begin
        rsh_r[ri_r] <= rxs;
        ri_r        <= (ri_r == `STE_IO_LAST) ? 4'h0 : ri_r + 4'h1;
      end
    end else begin
      case (st_r)
        ste_rx_idle: begin
          if (receive_enable_bit && !rxs) begin
            st_r        <= ste_rx_start;
            rc_r        <= bit_half;
            ri_r        <= 4'h0;
            parity_underrun_error_flag_pend_r <= 1'b0;
          end
        end
        ste_rx_start: begin
          if (rc_r == '0) begin
            st_r <= rxs ? ste_rx_idle : ste_rx_data;
            rc_r <= bit_full;
          end else begin
            rc_r <= rc_r - BW'(1);
          end
        end
        ste_rx_data: begin
          if (rc_r == '0) begin
            rsh_r[ri_r] <= rxs;
            ri_r        <= ri_r + 4'h1;
            rc_r        <= bit_full;
            if (ri_r == dbits - 4'h1) st_r <= pe ? ste_rx_par : ste_rx_stop;
          end else begin
            rc_r <= rc_r - BW'(1);
          end
        end
        ste_rx_par: begin
          if (rc_r == '0) begin
            parity_underrun_error_flag_pend_r <= rxs != par_of(rsh_r, len, ctrl_r[`STE_C_ODD]);
            st_r        <= ste_rx_stop;
            rc_r        <= bit_full;
          end else begin
            rc_r <= rc_r - BW'(1);
          end
        end
        ste_rx_stop: begin
          if (rc_r == '0) begin
            st_r <= ste_rx_idle;
          end else begin
            rc_r <= rc_r - BW'(1);
          end
        end
        default: st_r <= ste_rx_idle;
      endcase
    end
  end

  // Word completion and error events
  assign u_mid      = ~io & (st_r == ste_rx_stop) & (rc_r == '0);
  assign io_rx_last = io & receive_enable_bit & act & (ri_r == `STE_IO_LAST);
  assign rx_word    = u_mid | io_rx_last;
  assign rx_acc     = rx_word & (~rx_full_r | rxd_rd);
  assign rx_val     = io ? {1'b0, rxs, rsh_r[6:0]} : rsh_r;
  assign ovr_ev     = rx_word & rx_full_r & ~rxd_rd & ~(io & ckout);
  assign frm_ev     = u_mid & ~rxs;
  assign pun_ev     = (u_mid & parity_underrun_error_flag_pend_r)
                    | (io & ~ckout & txe & act & ~tx_run_r & ~buf_full_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxb_r     <= 9'h000;
      rx_full_r <= 1'b0;
    end else if (srst) begin
      rx_full_r <= 1'b0;
    end else if (rx_acc) begin
      rxb_r     <= rx_val;
      rx_full_r <= 1'b1;
    end else if (rxd_rd) begin
      rx_full_r <= 1'b0;
    end
  end

  // Error flags: event wins over any clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_r <= 1'b0;
      pun_r <= 1'b0;
      frm_r <= 1'b0;
    end else begin
      ovr_r <= ovr_ev | (ovr_r & ~stat_rd & ~srst);
      pun_r <= pun_ev | (pun_r & ~stat_rd & ~srst);
      frm_r <= frm_ev | (frm_r & ~stat_rd & ~srst);
    end
  end

  // Interrupt status, mask and output
  assign ev = {rx_acc, frm_ev, pun_ev, ovr_ev, tx_ev};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r  <= '0;
      mask_r <= `STE_MASK_RST;
    end else begin
      ist_r <= ev | (ist_r & ~{`STE_IRQ_W{irq_rd}});
      if (wr_en && paddr == `STE_A_MASK) mask_r <= pwdata[`STE_IRQ_W-1:0];
    end
  end

  assign transmit_interrupt = |(ist_r & mask_r);

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `STE_A_CTRL: prdata_r <= {14'h0000, ctrl_r};
        `STE_A_STAT: prdata_r <= {23'h000000, lvl_r, frm_r, pun_r, ovr_r,
                                  tx_run_r, rx_full_r, ~buf_full_r};
        `STE_A_IRQ:  prdata_r <= {27'h0000000, ist_r};
        `STE_A_MASK: prdata_r <= {27'h0000000, mask_r};
        `STE_A_RXD:  prdata_r <= {23'h000000, rxb_r};
        default:     prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_word_end;
    io && ckout && dbuf && !fifo && io_last && !buf_full_r;
  endsequence

  property p_async_single;
    u_stop && !dbuf && !fifo |=> ist_r[`STE_I_TX] && cnt_r == 4'h1 && tx_run_r;
  endproperty
  a_async_single: assert property (p_async_single) else $error("tx irq not before stop");

  property p_io_single;
    io_last && !dbuf && !fifo |=> ist_r[`STE_I_TX] && !tx_run_r;
  endproperty
  a_io_single: assert property (p_io_single) else $error("tx irq not at last edge");

  property p_dbuf_move;
    ld && dbuf && !fifo |=> ist_r[`STE_I_TX] && tx_run_r && !buf_full_r;
  endproperty
  a_dbuf_move: assert property (p_dbuf_move) else $error("tx irq not at move");

  property p_fifo_eq;
    fifo && !ctrl_r[`STE_C_FIS] && f_push && !f_pop && lvl_r + 3'h1 == thr
      |=> ist_r[`STE_I_TX] && lvl_r == thr;
  endproperty
  a_fifo_eq: assert property (p_fifo_eq) else $error("fifo level irq missed");

  property p_fifo_pop_quiet;
    fifo && ctrl_r[`STE_C_FIS] && f_pop && !f_push && !ist_r[`STE_I_TX] && !irq_rd
      |=> !ist_r[`STE_I_TX];
  endproperty
  a_fifo_pop_quiet: assert property (p_fifo_pop_quiet) else $error("irq on pop");

  property p_framing;
    u_mid && !rxs && !stat_rd |=> frm_r && st_r == ste_rx_idle;
  endproperty
  a_framing: assert property (p_framing) else $error("framing not flagged");

  property p_io_overrun;
    io_rx_last && !ckout && rx_full_r && !rxd_rd |=> ovr_r && rx_full_r;
  endproperty
  a_io_overrun: assert property (p_io_overrun) else $error("overrun not flagged");

  property p_ckout_quiet;
    io && ckout && !ovr_r && !pun_r |=> !ovr_r && !pun_r;
  endproperty
  a_ckout_quiet: assert property (p_ckout_quiet) else $error("error in clock output");

  property p_soft_reset;
    srst |=> !txe && !receive_enable_bit && !tx_run_r && !buf_full_r && !rx_full_r &&
             (!ovr_r || $past(ovr_ev));
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");

  property p_clock_stop;
    s_word_end |=> !tx_run_r && !ist_r[`STE_I_TX] ##1 !tx_run_r;
  endproperty
  a_clock_stop: assert property (p_clock_stop) else $error("clock kept running");

endmodule

// ---- core/ste_pkg.sv ----
// Shared types of the serial channel
package ste_pkg;
  typedef enum logic [2:0] {
    ste_rx_idle  = 3'h0,
    ste_rx_start = 3'h1,
    ste_rx_data  = 3'h2,
    ste_rx_par   = 3'h3,
    ste_rx_stop  = 3'h4
  } ste_rx_state_type;
endpackage

// ---- testbench/ste_peer.sv ----
// Serial peer model: async frame source and link clock source
module ste_peer #(
  parameter int BIT_CYCLES = 4
) (
  input  wire logic pclk,
  output logic      peer_clk,
  output logic      peer_rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    peer_clk = 1'b0;
    peer_rxd = 1'b1;
  end
  // Start, LSB-first data, parity, stop; then back to idle high
  task automatic send(input logic [7:0] d, input logic par, input logic stp);
    logic [10:0] f;
    f = {stp, par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge pclk);
      peer_rxd <= f[i];
      repeat (BIT_CYCLES - 1) @(posedge pclk);
    end
    @(posedge pclk);
    peer_rxd <= 1'b1;
  endtask
  // Link clock, 160 ns period, parked low between bursts
  task automatic clocks(input int n);
    repeat (n) begin
      repeat (8) @(posedge pclk);
      peer_clk <= 1'b1;
      repeat (8) @(posedge pclk);
      peer_clk <= 1'b0;
    end
  endtask
endmodule

// ---- testbench/tb.sv ----
// Testbench of the serial channel: APB master, scenarios, verdict
`include "ste_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int B = 4;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, err, sck_o, sck_oe, txl, irq, peer_clk, rxl, prev;
  wire         sck_i = sck_oe ? sck_o : peer_clk;
  int          miscompares = 0;
  int          samples_checked = 0;
  always #5 pclk = ~pclk;
  ste_core #(.BIT_CYCLES(B), .SCK_HALF(8), .FIFO_DEPTH(4)) u_ste_core (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_clock_pin_i(sck_i),
    .serial_clock_pin_o(sck_o), .serial_clock_pin_oe(sck_oe),
    .transmit_line_pin(txl), .receive_line_pin(rxl), .transmit_interrupt(irq));
  ste_peer #(.BIT_CYCLES(B)) u_ste_peer (.pclk(pclk), .peer_clk(peer_clk), .peer_rxd(rxl));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rise();
    prev = sck_o;
    repeat (100) begin
      cyc(1);
      if (prev === 1'b0 && sck_o === 1'b1) break;
      prev = sck_o;
    end
  endtask
  task automatic t_regs();
    apb(0, `STE_A_CTRL, 32'h0);
    chk("ctrl", 32'h0, q);
    apb(0, `STE_A_MASK, 32'h0);
    chk("mask", 32'h0, q);
    apb(0, 8'h18, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    $display("regs done");
  endtask
  task automatic t_srst();
    apb(1, `STE_A_CTRL, 32'h5003);
    apb(1, `STE_A_CTRL, 32'h9003);
    apb(1, `STE_A_CTRL, 32'h1003);
    apb(0, `STE_A_CTRL, 32'h0);
    chk("ctrl_en", 32'h3, q & 32'h3);
    apb(1, `STE_A_CTRL, 32'h9003);
    apb(1, `STE_A_CTRL, 32'h5003);
    apb(0, `STE_A_CTRL, 32'h0);
    chk("ctrl_en", 32'h0, q & 32'h3);
    apb(0, `STE_A_STAT, 32'h0);
    chk("stat", 32'h1, q & 32'h3F);
    $display("soft reset done");
  endtask
  task automatic t_async1();
    logic [7:0] d;
    apb(1, `STE_A_MASK, 32'h1);
    apb(1, `STE_A_CTRL, 32'h1005);
    apb(1, `STE_A_TXD, 32'hA5);
    repeat (10) if (txl !== 1'b0) cyc(1);
    cyc(B / 2);
    for (int i = 0; i < 8; i++) begin
      cyc(B);
      d[i] = txl;
    end
    chk("data", 32'hA5, {24'h0, d});
    cyc(B / 2 - 1);
    chk("irq_early", 32'h0, {31'h0, irq});
    cyc(1);
    chk("stop_irq", 32'h3, {30'h0, txl, irq});
    apb(0, `STE_A_IRQ, 32'h0);
    chk("irq_reg", 32'h1, q & 32'h1F);
    $display("async single done");
  endtask
  task automatic t_async2();
    apb(1, `STE_A_CTRL, 32'h1015);
    apb(1, `STE_A_TXD, 32'h5A);
    cyc(3);
    chk("irq_load", 32'h1, {31'h0, irq});
    cyc(12 * B);
    apb(0, `STE_A_IRQ, 32'h0);
    chk("irq_reg", 32'h1, q & 32'h1F);
    $display("async double done");
  endtask
  task automatic t_rx();
    apb(1, `STE_A_MASK, 32'hE);
    apb(1, `STE_A_CTRL, 32'h1806);
    fork
      u_ste_peer.send(8'hA5, 1'b1, 1'b1);
      begin
        cyc(10 * B + 3);
        chk("parity_underrun_error_flag_early", 32'h0, {31'h0, irq});
      end
    join
    cyc(4);
    apb(0, `STE_A_IRQ, 32'h0);
    chk("parity_underrun_error_flag", 32'h4, q & 32'hE);
    apb(0, `STE_A_RXD, 32'h0);
    u_ste_peer.send(8'hA5, 1'b0, 1'b0);
    cyc(4);
    apb(0, `STE_A_IRQ, 32'h0);
    chk("framing_error_flag", 32'h8, q & 32'hE);
    $display("receive errors done");
  endtask
  task automatic t_io1();
    logic [7:0] d;
    apb(1, `STE_A_MASK, 32'h7);
    apb(1, `STE_A_CTRL, 32'hC1);
    apb(1, `STE_A_TXD, 32'h3C);
    for (int i = 0; i < 8; i++) begin
      rise();
      d[i] = txl;
    end
    chk("oe", 32'h1, {31'h0, sck_oe});
    chk("io_data", 32'h3C, {24'h0, d});
    chk("irq_early", 32'h0, {31'h0, irq});
    repeat (4) if (irq !== 1'b1) cyc(1);
    chk("irq_word", 32'h1, {31'h0, irq});
    apb(0, `STE_A_IRQ, 32'h0);
    chk("io_err", 32'h1, q & 32'h7);
    $display("io out single done");
  endtask
  task automatic t_io2();
    apb(1, `STE_A_CTRL, 32'hD1);
    apb(1, `STE_A_TXD, 32'h81);
    cyc(3);
    chk("irq_load", 32'h1, {31'h0, irq});
    apb(0, `STE_A_IRQ, 32'h0);
    cyc(300);
    chk("quiet", 32'h0, {30'h0, irq, sck_o});
    apb(0, `STE_A_STAT, 32'h0);
    chk("stat", 32'h1, q & 32'h5);
    $display("io out double done");
  endtask
  task automatic t_io3();
    apb(1, `STE_A_MASK, 32'h4);
    apb(1, `STE_A_CTRL, 32'h83);
    cyc(2);
    chk("urun_early", 32'h0, {31'h0, irq});
    u_ste_peer.clocks(1);
    cyc(4);
    chk("urun", 32'h1, {31'h0, irq});
    chk("urun_line", 32'h0, {31'h0, txl});
    u_ste_peer.clocks(15);
    cyc(4);
    apb(0, `STE_A_IRQ, 32'h0);
    chk("orun", 32'h6, q & 32'h6);
    $display("io in done");
  endtask
  task automatic t_fifo();
    apb(0, `STE_A_IRQ, 32'h0);
    apb(1, `STE_A_CTRL, 32'h1524);
    apb(1, `STE_A_TXD, 32'h11);
    apb(0, `STE_A_IRQ, 32'h0);
    chk("fifo_below", 32'h1, q & 32'h1);
    apb(1, `STE_A_CTRL, 32'h1424);
    apb(1, `STE_A_TXD, 32'h22);
    apb(0, `STE_A_IRQ, 32'h0);
    chk("fifo_ne", 32'h0, q & 32'h1);
    apb(1, `STE_A_TXD, 32'h33);
    apb(0, `STE_A_IRQ, 32'h0);
    chk("fifo_eq", 32'h1, q & 32'h1);
    apb(1, `STE_A_CTRL, 32'h1524);
    apb(1, `STE_A_TXD, 32'h44);
    apb(0, `STE_A_IRQ, 32'h0);
    chk("fifo_above", 32'h0, q & 32'h1);
    apb(1, `STE_A_CTRL, 32'h1525);
    cyc(50 * B);
    apb(0, `STE_A_IRQ, 32'h0);
    chk("fifo_drain", 32'h0, q & 32'h1);
    apb(0, `STE_A_STAT, 32'h0);
    chk("fifo_stat", 32'h1, q & 32'h1C5);
    $display("fifo done");
  endtask
  task automatic conclude();
    $display("checked %0d bad %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_srst();
    t_async1();
    t_async2();
    t_rx();
    t_io1();
    t_io2();
    t_io3();
    t_fifo();
    conclude();
  end
  initial begin
    #100000;
    miscompares++;
    conclude();
  end
endmodule
